/* stcmd_unit.sv */
// speed/torque mode command unit with apb register slave
//
// Contract
// - speed command abort keeps executing flag set until abort completes
// - speed command keeps hold-completed and execution-completed flags clear
// - error in speed command sets error-end, decel stop; cleared by other command
// - distribution-done set when distribution finishes, clear during move
// - in-position only when distribution done and position inside window
// - proximity follows done when width zero, else position difference below width
// - code 24 selects torque control and reports response 24 while running
// - torque command runs even with servo power off
// - torque reference changes apply live without restart
// - pause bit ignored during torque command, no hold
// - abort bit decelerates axis; abort done once stopped
// - abort released mid-processing resumes torque mode
// - command change during torque runs the same abort sequence
// - servo bit energises motor; torque starts when servo turned on
// - loop select bit picks pi at 0, p-only at 1
// - torque-mode speed limit is a percentage of rated speed
// - position tracking from feedback continues in torque mode
// - torque command only on second-generation network, rejected otherwise
// - torque command abort keeps executing flag set until abort completes
// - torque command keeps hold-completed and execution-completed flags clear
//
// The APB register port and the register offsets are this design's own decisions.
module stcmd_unit
    import stcmd_pkg::*;
#(
    parameter int SCAN_CYC = STCMD_SCAN_CYC
)
(
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // amplifier side
    input  wire logic        axis_stopped_i,
    input  wire logic        dist_busy_i,
    input  wire logic        amp_error_i,
    input  wire logic [31:0] fb_position_i,
    output stcmd_amp_s       amp_o,
    output stcmd_flags_s     flags_o
);

    // ****************************************
    // state encoding
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_RUN   = 4'b0010,
        ST_ABORT = 4'b0100,
        ST_ERR   = 4'b1000
    } stcmd_state_e;

    // ****************************************
    // registers
    // ****************************************
    logic [31:0]  cmd_r;
    logic [31:0]  trq_r;
    logic [31:0]  spdlim_r;
    logic [15:0]  func_r;
    logic [31:0]  width1_r;
    logic [31:0]  width2_r;
    logic         proto2_r;
    logic [31:0]  actual_machine_position_r;
    logic [31:0]  commanded_machine_position_r;
    logic [7:0]   resp_r;
    logic [7:0]   run_code_r;
    stcmd_state_e state_r;
    stcmd_state_e state_nxt;
    logic [31:0]  scan_cnt_r;
    logic         err_r;
    stcmd_flags_s flags_r;
    stcmd_amp_s   amp_r;
    logic [31:0]  prdata_r;
    logic         pready_r;
    logic         pslverr_r;

    // ****************************************
    // apb decode
    // ****************************************
    wire         apb_setup   = psel_i & ~penable_i;
    wire         apb_wr      = psel_i & penable_i & pwrite_i & pready_r;
    wire         hit_cmd     = paddr_i == STCMD_OFS_CMD;
    wire         hit_trq     = paddr_i == STCMD_OFS_TRQ;
    wire         hit_spdlim  = paddr_i == STCMD_OFS_SPDLIM;
    wire         hit_func    = paddr_i == STCMD_OFS_FUNC;
    wire         hit_w1      = paddr_i == STCMD_OFS_WIDTH1;
    wire         hit_w2      = paddr_i == STCMD_OFS_WIDTH2;
    wire         hit_proto   = paddr_i == STCMD_OFS_PROTO;
    wire         hit_status  = paddr_i == STCMD_OFS_STATUS;
    wire         hit_resp    = paddr_i == STCMD_OFS_RESP;
    wire         hit_commanded_machine_position    = paddr_i == STCMD_OFS_COMMANDED_MACHINE_POSITION;
    wire         hit_actual_machine_position    = paddr_i == STCMD_OFS_ACTUAL_MACHINE_POSITION;
    wire         hit_any     = hit_cmd | hit_trq | hit_spdlim | hit_func | hit_w1 | hit_w2 |
                               hit_proto | hit_status | hit_resp | hit_commanded_machine_position | hit_actual_machine_position;
    wire         hit_ro      = hit_status | hit_resp | hit_commanded_machine_position | hit_actual_machine_position;
    wire         bad_acc     = ~hit_any | (pwrite_i & hit_ro);

    wire [31:0] status_word =
        {12'h000, flags_r.prox, 1'b0, flags_r.in_pos, flags_r.distribution_done_flag,
         7'h00, flags_r.exec_done, 4'h0, flags_r.err_end, 1'b0, flags_r.hold_done, flags_r.exec};

    wire [31:0] rd_mux =
        hit_cmd    ? cmd_r :
        hit_trq    ? trq_r :
        hit_spdlim ? spdlim_r :
        hit_func   ? {16'h0000, func_r} :
        hit_w1     ? width1_r :
        hit_w2     ? width2_r :
        hit_proto  ? {31'h0000_0000, proto2_r} :
        hit_status ? status_word :
        hit_resp   ? {24'h00_0000, resp_r} :
        hit_commanded_machine_position   ? commanded_machine_position_r :
        hit_actual_machine_position   ? actual_machine_position_r : 32'h0000_0000;

    // ****************************************
    // command field decode
    // ****************************************
    wire [7:0] cmd_code   = cmd_r[STCMD_CMD_LSB +: 8];
    wire       abort_bit  = cmd_r[STCMD_ABORT_BIT];
    wire       servo_bit  = cmd_r[STCMD_SERVO_BIT];
    wire       loop_bit   = cmd_r[STCMD_LOOP_BIT];
    wire       is_known   = (cmd_code == STCMD_CODE_TRQ) | (cmd_code == STCMD_CODE_SPEED_REFERENCE_COMMAND);
    // torque command is legal only on the second-generation network
    // protocol gate
    wire       code_legal = (cmd_code != STCMD_CODE_TRQ) | proto2_r;
    wire       scan_tick  = scan_cnt_r == 32'(SCAN_CYC - 1);
    wire       cmd_change = cmd_code != run_code_r;
    // position difference for proximity
    wire [31:0] pos_diff  = (commanded_machine_position_r >= actual_machine_position_r) ? commanded_machine_position_r - actual_machine_position_r : actual_machine_position_r - commanded_machine_position_r;

    // ****************************************
    // apb response, no wait states
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pready_r  <= 1'b0;
            prdata_r  <= STCMD_RST_WORD;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= apb_setup;
            prdata_r  <= (apb_setup & ~pwrite_i) ? rd_mux : STCMD_RST_WORD;
            pslverr_r <= apb_setup & bad_acc;
        end
    end

    // ****************************************
    // software settings
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cmd_r    <= STCMD_RST_WORD;
            trq_r    <= STCMD_RST_WORD;
            spdlim_r <= STCMD_RST_WORD;
            func_r   <= 16'h0000;
            width1_r <= STCMD_RST_WORD;
            width2_r <= STCMD_RST_WORD;
            proto2_r <= STCMD_RST_PROTO;
        end
        else if (apb_wr & ~pslverr_r)
        begin
            if (hit_cmd)    cmd_r    <= pwdata_i;
            if (hit_trq)    trq_r    <= pwdata_i;
            if (hit_spdlim) spdlim_r <= pwdata_i;
            if (hit_func)   func_r   <= pwdata_i[15:0];
            if (hit_w1)     width1_r <= pwdata_i;
            if (hit_w2)     width2_r <= pwdata_i;
            if (hit_proto)  proto2_r <= pwdata_i[0];
        end
    end

    // ****************************************
    // scan divider
    // ****************************************
    // scan pacing
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            scan_cnt_r <= 32'h0000_0000;
        else
            scan_cnt_r <= scan_tick ? 32'h0000_0000 : scan_cnt_r + 32'h0000_0001;
    end

    // ****************************************
    // command sequencer
    // ****************************************
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (is_known & code_legal & ~abort_bit)
                    state_nxt = ST_RUN;
                else if (is_known & ~code_legal)
                    state_nxt = ST_ERR;
            ST_RUN:
                if (amp_error_i)
                    state_nxt = ST_ERR;
                else if (abort_bit | cmd_change)
                    state_nxt = ST_ABORT;
            ST_ABORT:
                if (~abort_bit & ~cmd_change)
                    state_nxt = ST_RUN;
                else if (axis_stopped_i)
                    state_nxt = ST_IDLE;
            ST_ERR:
                if (axis_stopped_i & cmd_change & is_known & code_legal)
                    state_nxt = ST_RUN;
                else if (axis_stopped_i & (cmd_code == STCMD_CODE_NONE))
                    state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // state and latched command advance only on scan boundaries
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_r    <= ST_IDLE;
            run_code_r <= STCMD_CODE_NONE;
        end
        else if (scan_tick)
        begin
            state_r <= state_nxt;
            if (state_nxt == ST_RUN && state_r != ST_RUN)
                run_code_r <= cmd_code;
            else if (state_nxt == ST_IDLE || (state_nxt == ST_ERR && state_r == ST_IDLE))
                run_code_r <= cmd_code;
        end
    end

    // ****************************************
    // error flag and positions
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            err_r  <= 1'b0;
            actual_machine_position_r <= STCMD_RST_WORD;
            commanded_machine_position_r <= STCMD_RST_WORD;
        end
        else if (scan_tick)
        begin
            if (state_nxt == ST_ERR)
                err_r <= 1'b1;
            else if (state_nxt == ST_RUN && state_r != ST_RUN)
                err_r <= 1'b0;
            actual_machine_position_r <= fb_position_i;
            // commanded position follows feedback outside move distribution
            if (!dist_busy_i)
                commanded_machine_position_r <= fb_position_i;
        end
    end

    // ****************************************
    // monitor flags and response code
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            flags_r <= '0;
            resp_r  <= STCMD_CODE_NONE;
        end
        else if (scan_tick)
        begin
            flags_r.exec      <= state_nxt == ST_ABORT;
            flags_r.hold_done <= 1'b0;
            flags_r.exec_done <= 1'b0;
            flags_r.err_end   <= (state_nxt == ST_ERR) | (err_r & ~(state_nxt == ST_RUN && state_r != ST_RUN));
            flags_r.distribution_done_flag       <= ~dist_busy_i;
            flags_r.in_pos    <= ~dist_busy_i & (pos_diff <= width1_r);
            flags_r.prox      <= (width2_r == 32'h0000_0000) ? ~dist_busy_i : (pos_diff < width2_r);
            resp_r            <= (state_nxt == ST_RUN || state_nxt == ST_ABORT) ? run_code_r : STCMD_CODE_NONE;
            if (state_nxt == ST_RUN && state_r != ST_RUN)
                resp_r <= cmd_code;
        end
    end

    // ****************************************
    // amplifier command
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            amp_r <= '0;
        else
        begin
            amp_r.servo_on    <= servo_bit;
            amp_r.p_only      <= loop_bit;
            amp_r.torque_mode <= (state_r == ST_RUN) & (run_code_r == STCMD_CODE_TRQ);
            amp_r.speed_mode  <= (state_r == ST_RUN) & (run_code_r == STCMD_CODE_SPEED_REFERENCE_COMMAND);
            amp_r.decel_stop  <= (state_r == ST_ABORT) | (state_r == ST_ERR);
            amp_r.torque_ref  <= trq_r;
            amp_r.speed_lim   <= spdlim_r;
            amp_r.func_set    <= func_r;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata_o  = prdata_r;
    assign pready_o  = pready_r;
    assign pslverr_o = pslverr_r;
    assign amp_o     = amp_r;
    assign flags_o   = flags_r;

endmodule

/* stcmd_pkg.sv */
// package for the speed/torque mode command unit
package stcmd_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] STCMD_OFS_CMD     = 8'h00; // motion command, pause, abort, servo, loop sel
    localparam logic [7:0] STCMD_OFS_TRQ     = 8'h04; // torque reference value
    localparam logic [7:0] STCMD_OFS_SPDLIM  = 8'h08; // speed limit, percent of rated
    localparam logic [7:0] STCMD_OFS_FUNC    = 8'h0C; // unit and filter setting
    localparam logic [7:0] STCMD_OFS_WIDTH1  = 8'h10; // positioning completed width
    localparam logic [7:0] STCMD_OFS_WIDTH2  = 8'h14; // second completion width
    localparam logic [7:0] STCMD_OFS_PROTO   = 8'h18; // bit0: second-generation network
    localparam logic [7:0] STCMD_OFS_STATUS  = 8'h20; // monitor flags
    localparam logic [7:0] STCMD_OFS_RESP    = 8'h24; // command response code
    localparam logic [7:0] STCMD_OFS_COMMANDED_MACHINE_POSITION    = 8'h28; // commanded machine position
    localparam logic [7:0] STCMD_OFS_ACTUAL_MACHINE_POSITION    = 8'h2C; // actual machine position

    // command register field positions
    localparam int STCMD_CMD_LSB    = 0;
    localparam int STCMD_PAUSE_BIT  = 8;
    localparam int STCMD_ABORT_BIT  = 9;
    localparam int STCMD_SERVO_BIT  = 10;
    localparam int STCMD_LOOP_BIT   = 11;

    // status register bit positions
    localparam int STCMD_ST_EXEC    = 0;
    localparam int STCMD_ST_HOLD    = 1;
    localparam int STCMD_ST_ERR     = 3;
    localparam int STCMD_ST_EXDONE  = 8;
    localparam int STCMD_ST_DEN     = 16;
    localparam int STCMD_ST_INPOS   = 17;
    localparam int STCMD_ST_PROX    = 19;

    // motion command codes
    localparam logic [7:0] STCMD_CODE_NONE = 8'h00;
    localparam logic [7:0] STCMD_CODE_SPEED_REFERENCE_COMMAND = 8'h17; // 23
    localparam logic [7:0] STCMD_CODE_TRQ  = 8'h18; // 24

    // reset values
    localparam logic [31:0] STCMD_RST_WORD  = 32'h0000_0000;
    localparam logic        STCMD_RST_PROTO = 1'b1;

    // scan period
    localparam int STCMD_CLK_HZ        = 50_000_000;
    localparam int STCMD_SCAN_US       = 1000;
    localparam int STCMD_SCAN_CYC      = STCMD_CLK_HZ / 1_000_000 * STCMD_SCAN_US;

    // flags shown to software
    typedef struct packed {
        logic exec;
        logic hold_done;
        logic err_end;
        logic exec_done;
        logic distribution_done_flag;
        logic in_pos;
        logic prox;
    } stcmd_flags_s;

    // commands driven toward the servo amplifier
    typedef struct packed {
        logic        servo_on;
        logic        p_only;
        logic        torque_mode;
        logic        speed_mode;
        logic        decel_stop;
        logic [31:0] torque_ref;
        logic [31:0] speed_lim;
        logic [15:0] func_set;
    } stcmd_amp_s;

endpackage

/* stcmd_unit_checker.sv */
// port assertions for the speed/torque command unit
module stcmd_unit_checker
    import stcmd_pkg::*;
#(
    parameter int SCAN_CYC = 8
)
(
    input wire logic         ref_clk_i,
    input wire logic         arst_n_i,
    input wire logic         psel_i,
    input wire logic         penable_i,
    input wire logic         pwrite_i,
    input wire logic [7:0]   paddr_i,
    input wire logic [31:0]  prdata_o,
    input wire logic         pready_o,
    input wire logic         pslverr_o,
    input wire stcmd_amp_s   amp_o,
    input wire stcmd_flags_s flags_o
);
    // ****************************************
    // flag and bus relations
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    a_hold_clear: assert property (!flags_o.hold_done && !flags_o.exec_done)
        else $error("hold or completion flag set");
    a_inpos_den: assert property (flags_o.in_pos |-> flags_o.distribution_done_flag)
        else $error("in-position without distribution done");
    a_scan_step: assert property ($changed(flags_o) |=> $stable(flags_o)[*7])
        else $error("flags changed between scans");
    a_err_decel: assert property ($rose(flags_o.err_end) |=> amp_o.decel_stop)
        else $error("error end without decel stop");
    a_abort_decel: assert property ($rose(flags_o.exec) |=> amp_o.decel_stop)
        else $error("abort without decel stop");
    a_apb_answer: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no answer after setup");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside access");
    a_ro_refused: assert property (pready_o && pwrite_i && paddr_i >= STCMD_OFS_STATUS
        && paddr_i <= STCMD_OFS_ACTUAL_MACHINE_POSITION |-> pslverr_o)
        else $error("read-only write not refused");

    c_abort: cover property ($rose(flags_o.exec));
    c_abort_done: cover property ($fell(flags_o.exec));
    c_err: cover property ($rose(flags_o.err_end));
    c_refused: cover property (pready_o && pslverr_o);
endmodule

/* stcmd_amp_model.sv */
// servo amplifier model answering the command unit
module stcmd_amp_model
    import stcmd_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire stcmd_amp_s cmd_i,
    input  wire logic       slow_i,
    input  wire logic       fault_i,
    input  wire logic       busy_i,
    output logic            stopped_o,
    output logic            busy_o,
    output logic            error_o,
    output logic [31:0]     pos_o
);
    logic [7:0] speed_r;
    logic [7:0] step;

    // slow mode stretches the ramp down
    assign step      = slow_i ? 8'h01 : 8'h08;
    assign stopped_o = (speed_r == 8'h00);

    // torque only with servo on, ramp to rest on decel
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            speed_r <= 8'h00;
            pos_o   <= 32'h0;
            busy_o  <= 1'b0;
            error_o <= 1'b0;
        end
        else
        begin
            if (cmd_i.decel_stop || !cmd_i.servo_on || !cmd_i.torque_mode)
                speed_r <= (speed_r > step) ? speed_r - step : 8'h00;
            else
                speed_r <= {2'b00, cmd_i.torque_ref[5:0]};
            pos_o   <= pos_o + {24'h0, speed_r};
            busy_o  <= busy_i;
            error_o <= fault_i;
        end
    end
endmodule

/* stcmd_unit_bench.sv */
// self-checking bench for the speed/torque command unit
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) \
    begin miscompares++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module stcmd_unit_bench
    import stcmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         ref_clk_i = 1'b0;
    logic         arst_n_i  = 1'b0;
    logic         psel_i    = 1'b0;
    logic         penable_i = 1'b0;
    logic         pwrite_i  = 1'b0;
    logic [7:0]   paddr_i   = 8'h00;
    logic [31:0]  pwdata_i  = 32'h0;
    logic         slow      = 1'b0;
    logic         fault     = 1'b0;
    logic         busy      = 1'b0;
    logic [31:0]  seed      = 32'h14;
    logic [31:0]  prdata_o, fb_position_i;
    logic         pready_o, pslverr_o, axis_stopped_i, dist_busy_i, amp_error_i;
    stcmd_amp_s   amp_o;
    stcmd_flags_s flags_o;
    logic [33:0]  expq[$];
    logic [33:0]  exp_e;
    int           miscompares = 0;
    int           num_checks  = 0;
    int           cyc         = 0;
    localparam logic [31:0] ST_IDLE = 32'h000B_0000;

    // clock
    initial
    begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    stcmd_unit #(.SCAN_CYC(8)) u_stcmd_unit
    (
        .ref_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .axis_stopped_i, .dist_busy_i,
        .amp_error_i, .fb_position_i, .amp_o, .flags_o
    );

    stcmd_amp_model u_stcmd_amp_model
    (
        .clk_i(ref_clk_i), .rst_n_i(arst_n_i), .cmd_i(amp_o), .slow_i(slow),
        .fault_i(fault), .busy_i(busy), .stopped_o(axis_stopped_i),
        .busy_o(dist_busy_i), .error_o(amp_error_i), .pos_o(fb_position_i)
    );

    // ****************************************
    // bus tasks
    // ****************************************
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do
            @(posedge ref_clk_i);
        while (pready_o !== 1'b1 && ++n < 16);
        if (n >= 16)
        begin
            miscompares++;
            wrap_up();
        end
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
        expq.push_back({1'b0, e, 32'h0});
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
        expq.push_back({1'b1, e, d});
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // compare each bus answer with the oldest note
    always @(posedge ref_clk_i)
    begin
        if (psel_i && penable_i && pready_o === 1'b1 && expq.size() > 0)
        begin
            exp_e = expq.pop_front();
            `CHK("pslverr", exp_e[32], pslverr_o)
            if (exp_e[33])
                `CHK("prdata", exp_e[31:0], prdata_o)
        end
    end

    // hang guard
    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        rd(STCMD_OFS_CMD, STCMD_RST_WORD);
        rd(STCMD_OFS_PROTO, {31'h0, STCMD_RST_PROTO});
        rd(8'h30, 32'h0, 1'b1);
        wr(STCMD_OFS_ACTUAL_MACHINE_POSITION, 32'hFFFF_FFFF, 1'b1);
        rd(STCMD_OFS_RESP, 32'h0);
        rd(STCMD_OFS_STATUS, ST_IDLE);
        wr(STCMD_OFS_FUNC, 32'h0000_00A5);
        wr(STCMD_OFS_CMD, 32'h0000_0118);
        tick(24);
        rd(STCMD_OFS_RESP, 32'h18);
        rd(STCMD_OFS_STATUS, ST_IDLE);
        `CHK("torque_mode", 1'b1, amp_o.torque_mode)
        `CHK("servo_on", 1'b0, amp_o.servo_on)
        `CHK("func_set", 16'h00A5, amp_o.func_set)
        wr(STCMD_OFS_SPDLIM, 32'd50);
        for (int i = 0; i < 3; i++)
        begin
            seed = xs(seed);
            wr(STCMD_OFS_TRQ, seed);
            wr(STCMD_OFS_CMD, 32'h0418 | (32'(i & 1) << 11));
            tick(24);
            `CHK("torque_ref", seed, amp_o.torque_ref)
            `CHK("p_only", 1'(i & 1), amp_o.p_only)
            `CHK("servo_on", 1'b1, amp_o.servo_on)
        end
        `CHK("speed_lim", 32'd50, amp_o.speed_lim)
        slow <= 1'b1;
        wr(STCMD_OFS_TRQ, 32'h3F);
        tick(16);
        wr(STCMD_OFS_CMD, 32'h0618);
        tick(24);
        `CHK("exec", 1'b1, flags_o.exec)
        `CHK("decel", 1'b1, amp_o.decel_stop)
        wr(STCMD_OFS_CMD, 32'h0418);
        tick(24);
        `CHK("exec", 1'b0, flags_o.exec)
        rd(STCMD_OFS_RESP, 32'h18);
        wr(STCMD_OFS_CMD, 32'h0618);
        tick(120);
        `CHK("exec", 1'b0, flags_o.exec)
        rd(STCMD_OFS_RESP, 32'h0);
        wr(STCMD_OFS_CMD, 32'h0418);
        tick(24);
        wr(STCMD_OFS_CMD, 32'h0417);
        tick(24);
        `CHK("exec", 1'b1, flags_o.exec)
        tick(120);
        rd(STCMD_OFS_RESP, 32'h17);
        `CHK("speed_mode", 1'b1, amp_o.speed_mode)
        fault <= 1'b1;
        tick(24);
        `CHK("err_end", 1'b1, flags_o.err_end)
        fault <= 1'b0;
        wr(STCMD_OFS_CMD, 32'h0418);
        tick(24);
        `CHK("err_end", 1'b0, flags_o.err_end)
        wr(STCMD_OFS_CMD, 32'h0);
        tick(120);
        wr(STCMD_OFS_PROTO, 32'h0);
        wr(STCMD_OFS_CMD, 32'h0018);
        tick(24);
        `CHK("err_end", 1'b1, flags_o.err_end)
        `CHK("torque_mode", 1'b0, amp_o.torque_mode)
        wr(STCMD_OFS_PROTO, 32'h1);
        wr(STCMD_OFS_CMD, 32'h0);
        busy <= 1'b1;
        wr(STCMD_OFS_WIDTH2, 32'h5);
        tick(24);
        // error end stays set until another command starts
        rd(STCMD_OFS_STATUS, 32'h0008_0008);
        wr(STCMD_OFS_WIDTH2, 32'h0);
        tick(24);
        rd(STCMD_OFS_STATUS, 32'h0000_0008);
        busy <= 1'b0;
        tick(24);
        rd(STCMD_OFS_STATUS, ST_IDLE | 32'h0000_0008);
        tick(4);
        wrap_up();
    end
endmodule

bind stcmd_unit stcmd_unit_checker #(.SCAN_CYC(SCAN_CYC)) u_stcmd_unit_checker
(
    .ref_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .prdata_o, .pready_o, .pslverr_o, .amp_o, .flags_o
);
